// *** design/gpio_params.svh ***
// Register map, field positions and reset values of the three-port GPIO
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH
`define ADDR_PORT_A_LATCH 8'h00
`define ADDR_PORT_B_LATCH 8'h01
`define ADDR_PORT_C_LATCH 8'h02
`define ADDR_PORT_A_DIR 8'h04
`define ADDR_PORT_B_DIR 8'h05
`define ADDR_PORT_C_DIR 8'h06
`define ADDR_SHARE_CTRL 8'h07
`define PORT_A_WIDTH 7
`define PORT_B_WIDTH 8
`define PORT_C_WIDTH 5
`define CLKOUT_EN_BIT 7
`define CLKOUT_PIN 2
`define TIMER_PIN_LO 6
`define SHARE_CONV_EN_BIT 5
`define SHARE_TIMER0_BIT 6
`define SHARE_TIMER1_BIT 7
`define DIR_RESET 8'h00
`define SHARE_RESET 8'h00
`define CONV_CH_MSB 4
`endif

// *** design/gpio_pkg.sv ***
// Types shared by the GPIO design files
package gpio_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    PIN_GPIO = 2'b00,
    PIN_TIMER = 2'b01,
    PIN_CONV = 2'b10
  } pin_use_t;
endpackage : gpio_pkg

// *** design/gpio_sync.sv ***
// Two-flop synchroniser for a bus of pin inputs
`timescale 1ns/100ps
`default_nettype none
module gpio_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : gpio_sync
`default_nettype wire

// *** design/three_port_gpio.sv ***
// Three-port GPIO with converter, timer and clock-out pin sharing
//
// Added by the designer: the plain strobed port.
`include "gpio_params.svh"
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Latch bit per pin, untouched by reset
// - Direction one drives pin, zero tristates
// - Reset clears all direction bits
// - Read gives latch if output, else pin
// - Writes always update latch
// - Converter wins over timer on shared pins
// - Converter pin reads zero when input
// - Channel select picks analog or GPIO
// - Timer select bits pick timer or GPIO
// - Shared pin drive ignores direction bit
// - Direction C bit seven drives clock out
// - Clock enable governs port C pin two
// - Reset clears C direction and clock enable
module three_port_gpio
  import gpio_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Converter and timer requests
  input wire logic [`CONV_CH_MSB:0] converter_channel_select,
  input wire logic [1:0] timer_out,
  output logic [1:0] timer_in,
  // Port A pins
  input wire logic [`PORT_A_WIDTH-1:0] pa_in,
  output logic [`PORT_A_WIDTH-1:0] pa_out,
  output logic [`PORT_A_WIDTH-1:0] pa_oe,
  // Port B pins
  input wire logic [`PORT_B_WIDTH-1:0] pb_in,
  output logic [`PORT_B_WIDTH-1:0] pb_out,
  output logic [`PORT_B_WIDTH-1:0] pb_oe,
  output logic [`PORT_B_WIDTH-1:0] pb_analog,
  // Port C pins
  input wire logic [`PORT_C_WIDTH-1:0] pc_in,
  output logic [`PORT_C_WIDTH-1:0] pc_out,
  output logic [`PORT_C_WIDTH-1:0] pc_oe
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [`PORT_A_WIDTH-1:0] pa_sync;
  logic [`PORT_B_WIDTH-1:0] pb_sync;
  logic [`PORT_C_WIDTH-1:0] pc_sync;
  gpio_sync #(.W(`PORT_A_WIDTH)) u_sync_a (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .async_in(pa_in),
    .sync_out(pa_sync)
  );
  gpio_sync #(.W(`PORT_B_WIDTH)) u_sync_b (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .async_in(pb_in),
    .sync_out(pb_sync)
  );
  gpio_sync #(.W(`PORT_C_WIDTH)) u_sync_c (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .async_in(pc_in),
    .sync_out(pc_sync)
  );

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire sel_a_lat = reg_addr == `ADDR_PORT_A_LATCH;
  wire sel_b_lat = reg_addr == `ADDR_PORT_B_LATCH;
  wire sel_c_lat = reg_addr == `ADDR_PORT_C_LATCH;
  wire sel_a_dir = reg_addr == `ADDR_PORT_A_DIR;
  wire sel_b_dir = reg_addr == `ADDR_PORT_B_DIR;
  wire sel_c_dir = reg_addr == `ADDR_PORT_C_DIR;
  wire sel_share = reg_addr == `ADDR_SHARE_CTRL;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Latches have no reset so their content survives it
  logic [`PORT_A_WIDTH-1:0] port_a_latch_q;
  logic [`PORT_B_WIDTH-1:0] port_b_latch_q;
  logic [`PORT_C_WIDTH-1:0] port_c_latch_q;
  logic [7:0] port_a_direction_q;
  logic [7:0] port_b_direction_q;
  logic [7:0] port_c_direction_q;
  logic [7:0] share_ctrl_q;

  always_ff @(posedge clk_sys) begin
    if (reg_wr && sel_a_lat) begin
      port_a_latch_q <= reg_wdata[`PORT_A_WIDTH-1:0];
    end
    if (reg_wr && sel_b_lat) begin
      port_b_latch_q <= reg_wdata;
    end
    if (reg_wr && sel_c_lat) begin
      port_c_latch_q <= reg_wdata[`PORT_C_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      port_a_direction_q <= `DIR_RESET;
      port_b_direction_q <= `DIR_RESET;
      port_c_direction_q <= `DIR_RESET;
      share_ctrl_q <= `SHARE_RESET;
    end else if (reg_wr) begin
      if (sel_a_dir) begin
        port_a_direction_q <= {1'b0, reg_wdata[`PORT_A_WIDTH-1:0]};
      end
      if (sel_b_dir) begin
        port_b_direction_q <= reg_wdata;
      end
      if (sel_c_dir) begin
        port_c_direction_q <= {reg_wdata[7], 2'b00,
                               reg_wdata[`PORT_C_WIDTH-1:0]};
      end
      if (sel_share) begin
        share_ctrl_q <= {reg_wdata[7:5], 5'b0_0000};
      end
    end
  end

  // ------------------------------------------------------------
  // Pin sharing on port B
  // ------------------------------------------------------------
  // Converter is only connected while its enable bit is set
  wire conv_en = share_ctrl_q[`SHARE_CONV_EN_BIT];
  wire [1:0] timer_en = {share_ctrl_q[`SHARE_TIMER1_BIT],
                         share_ctrl_q[`SHARE_TIMER0_BIT]};
  wire [7:0] conv_pin;
  wire [7:0] timer_pin;
  pin_use_t pin_use [`PORT_B_WIDTH];
  genvar gi;
  generate
    for (gi = 0; gi < `PORT_B_WIDTH; gi = gi + 1) begin : g_pb
      assign conv_pin[gi] = conv_en &&
        (converter_channel_select == (`CONV_CH_MSB+1)'(gi));
      if (gi >= `TIMER_PIN_LO) begin : g_tmr
        assign timer_pin[gi] = timer_en[gi-`TIMER_PIN_LO] &&
          !conv_pin[gi];
      end else begin : g_notmr
        assign timer_pin[gi] = 1'b0;
      end
      assign pin_use[gi] = conv_pin[gi] ? PIN_CONV :
        (timer_pin[gi] ? PIN_TIMER : PIN_GPIO);
    end
  endgenerate

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  wire clkout_en = port_c_direction_q[`CLKOUT_EN_BIT];
  wire [7:0] pb_oe_d = port_b_direction_q & ~conv_pin & ~timer_pin;
  // Timer drive on its pins uses its own out value, not the direction
  wire [7:0] pb_timer_oe = timer_pin & {timer_out, 6'b00_0000};
  wire [7:0] pb_out_d = (port_b_latch_q & ~timer_pin) |
                        (timer_pin & {timer_out, 6'b00_0000});
  wire [`PORT_C_WIDTH-1:0] clk_mask = `PORT_C_WIDTH'(1 << `CLKOUT_PIN);
  wire [`PORT_C_WIDTH-1:0] pc_oe_d = clkout_en ?
    (port_c_direction_q[`PORT_C_WIDTH-1:0] | clk_mask) :
    port_c_direction_q[`PORT_C_WIDTH-1:0];

  // Clock toggles at half rate since outputs must be registered
  logic clk_div_q;
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      clk_div_q <= 1'b0;
      pa_out <= '0;
      pa_oe <= '0;
      pb_out <= '0;
      pb_oe <= '0;
      pb_analog <= '0;
      pc_out <= '0;
      pc_oe <= '0;
      timer_in <= '0;
    end else begin
      clk_div_q <= clkout_en ? !clk_div_q : 1'b0;
      pa_out <= port_a_latch_q;
      pa_oe <= port_a_direction_q[`PORT_A_WIDTH-1:0];
      pb_out <= pb_out_d;
      pb_oe <= pb_oe_d | pb_timer_oe;
      pb_analog <= conv_pin;
      pc_out <= clkout_en ?
        ((port_c_latch_q & ~clk_mask) | (clk_mask & {5{clk_div_q}})) :
        port_c_latch_q;
      pc_oe <= pc_oe_d;
      timer_in <= pb_sync[7:6] & timer_pin[7:6];
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  wire [7:0] pa_rd = {1'b0, (port_a_direction_q[`PORT_A_WIDTH-1:0] &
    port_a_latch_q) | (~port_a_direction_q[`PORT_A_WIDTH-1:0] &
    pa_sync)};
  wire [7:0] pb_pin_val = pb_sync & ~conv_pin;
  wire [7:0] pb_rd = (port_b_direction_q & port_b_latch_q) |
    (~port_b_direction_q & pb_pin_val);
  wire [`PORT_C_WIDTH-1:0] pc_raw =
    (port_c_direction_q[`PORT_C_WIDTH-1:0] & port_c_latch_q) |
    (~port_c_direction_q[`PORT_C_WIDTH-1:0] & pc_sync);
  wire [7:0] pc_rd = {3'b000, clkout_en ? (pc_raw & ~clk_mask) :
    pc_raw};
  wire [7:0] rd_mux = sel_a_lat ? pa_rd :
    sel_b_lat ? pb_rd :
    sel_c_lat ? pc_rd :
    sel_a_dir ? port_a_direction_q :
    sel_b_dir ? port_b_direction_q :
    sel_c_dir ? port_c_direction_q :
    sel_share ? share_ctrl_q : 8'h00;

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  dir_reset_a: assert property (@(posedge clk_sys)
    $rose(rst_n_q) |-> port_a_direction_q == 8'h00 &&
    port_b_direction_q == 8'h00)
    else $error("direction not cleared by reset");
  clk_reset_a: assert property (@(posedge clk_sys)
    $rose(rst_n_q) |-> !clkout_en && port_c_direction_q == 8'h00)
    else $error("port C direction not cleared");
  latch_wr_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    reg_wr && sel_b_lat |=> port_b_latch_q == $past(reg_wdata))
    else $error("latch write lost");
  oe_a_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    1'b1 |=> pa_oe == $past(port_a_direction_q[6:0]))
    else $error("port A drive mismatch");
  rd_a_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    reg_rd && sel_a_lat |=> reg_rdata == $past(pa_rd))
    else $error("port A read wrong");
  conv_rd_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    reg_rd && sel_b_lat && conv_en && converter_channel_select == 5'd3
    && !port_b_direction_q[3] |=> !reg_rdata[3])
    else $error("converter pin read not zero");
  conv_pri_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    conv_pin[7] |-> !timer_pin[7])
    else $error("timer kept converter pin");
  shared_oe_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    conv_pin[0] && $stable(conv_pin) |=> !pb_oe[0])
    else $error("converter pin driven");
  clk_oe_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    clkout_en |=> pc_oe[2])
    else $error("clock pin not driven");
  clk_rd_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    reg_rd && sel_c_lat && clkout_en |=> !reg_rdata[2])
    else $error("clock pin read not zero");

endmodule : three_port_gpio
`default_nettype wire

// *** dv/board_pins.sv ***
// Board-side model of the port pins
`timescale 1ns/100ps
`default_nettype none
module board_pins (
  // Drive from the block
  input wire logic [6:0] pa_out,
  input wire logic [6:0] pa_oe,
  input wire logic [7:0] pb_out,
  input wire logic [7:0] pb_oe,
  input wire logic [4:0] pc_out,
  input wire logic [4:0] pc_oe,
  // Levels the board forces on undriven pins
  input wire logic [7:0] ext,
  // Resolved pin levels
  output logic [6:0] pa_in,
  output logic [7:0] pb_in,
  output logic [4:0] pc_in
);
  // Driven bits follow the block, the rest the board; no pull, no hold
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext[6:0]);
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext);
  assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext[4:0]);
endmodule : board_pins
`default_nettype wire

// *** dv/test_three_port_gpio.sv ***
// Self-checking bench for the three-port GPIO
`include "gpio_params.svh"
`timescale 1ns/100ps
`default_nettype none
module test_three_port_gpio;
  import gpio_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  byte_t reg_addr = 8'h00;
  byte_t reg_wdata = 8'h00;
  byte_t reg_rdata;
  byte_t ext = 8'h00;
  logic [4:0] conv_sel = 5'h00;
  logic [1:0] timer_out = 2'h0;
  logic [6:0] pa_in, pa_out, pa_oe;
  logic [7:0] pb_in, pb_out, pb_oe, pb_analog;
  logic [4:0] pc_in, pc_out, pc_oe;
  logic clk_a;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  always #4 clk_sys = ~clk_sys;
  three_port_gpio dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .converter_channel_select(conv_sel),
    .timer_out(timer_out), .timer_in(), .pa_in(pa_in), .pa_out(pa_out),
    .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
    .pb_analog(pb_analog), .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe));
  board_pins board (.pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out),
    .pb_oe(pb_oe), .pc_out(pc_out), .pc_oe(pc_oe), .ext(ext),
    .pa_in(pa_in), .pb_in(pb_in), .pc_in(pc_in));
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle
  task automatic check(input byte_t got, input byte_t exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input byte_t a, input byte_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rdchk(input byte_t a, input byte_t exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask : rdchk
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdchk(`ADDR_PORT_A_DIR, 8'h00);
    rdchk(`ADDR_PORT_B_DIR, 8'h00);
    rdchk(`ADDR_PORT_C_DIR, 8'h00);
    check({1'b0, pa_oe} | pb_oe, 8'h00);
    check({3'h0, pc_oe}, 8'h00);
    rdchk(8'h03, 8'h00);
  endtask : t_reset
  task automatic t_port_a;
    ext <= 8'h2A;
    wr(`ADDR_PORT_A_LATCH, 8'h55);
    idle(3);
    rdchk(`ADDR_PORT_A_LATCH, 8'h2A);
    wr(`ADDR_PORT_A_DIR, 8'hFF);
    idle(3);
    rdchk(`ADDR_PORT_A_DIR, 8'h7F);
    rdchk(`ADDR_PORT_A_LATCH, 8'h55);
    check({1'b0, pa_oe}, 8'h7F);
    check({1'b0, pa_out}, 8'h55);
    // A second reset must keep the latch but drop the direction
    rstn <= 1'b0;
    idle(2);
    rstn <= 1'b1;
    idle(3);
    rdchk(`ADDR_PORT_A_DIR, 8'h00);
    wr(`ADDR_PORT_A_DIR, 8'h7F);
    rdchk(`ADDR_PORT_A_LATCH, 8'h55);
  endtask : t_port_a
  task automatic t_port_b;
    ext <= 8'hFF;
    wr(`ADDR_PORT_B_LATCH, 8'hA5);
    wr(`ADDR_PORT_B_DIR, 8'h0F);
    conv_sel <= 5'h04;
    wr(`ADDR_SHARE_CTRL, 8'h20);
    idle(4);
    check(pb_analog, 8'h10);
    rdchk(`ADDR_PORT_B_LATCH, 8'hE5);
    conv_sel <= 5'h02;
    idle(4);
    check(pb_oe, 8'h0B);
    rdchk(`ADDR_PORT_B_LATCH, 8'hF5);
    wr(`ADDR_SHARE_CTRL, 8'h40);
    timer_out <= 2'h1;
    idle(4);
    check(pb_oe, 8'h4F);
    check(pb_analog, 8'h00);
    wr(`ADDR_PORT_B_DIR, 8'h00);
    idle(4);
    check(pb_oe, 8'h40);
    conv_sel <= 5'h06;
    wr(`ADDR_SHARE_CTRL, 8'h60);
    idle(4);
    check(pb_analog, 8'h40);
    check(pb_oe, 8'h00);
    conv_sel <= 5'h03;
    idle(4);
    rdchk(`ADDR_PORT_B_LATCH, 8'hF7);
    wr(`ADDR_PORT_B_DIR, 8'h01);
    conv_sel <= 5'h00;
    idle(4);
    check(pb_oe, 8'h40);
  endtask : t_port_b
  task automatic t_clock_out;
    wr(`ADDR_PORT_C_LATCH, 8'h1F);
    wr(`ADDR_PORT_C_DIR, 8'h80);
    idle(4);
    #1;
    check({3'h0, pc_oe}, 8'h04);
    clk_a = pc_out[2];
    idle(1);
    #1;
    check({7'h00, pc_out[2]}, {7'h00, ~clk_a});
    rdchk(`ADDR_PORT_C_DIR, 8'h80);
    rdchk(`ADDR_PORT_C_LATCH, 8'h1B);
    wr(`ADDR_PORT_C_DIR, 8'h00);
    idle(4);
    check({3'h0, pc_oe}, 8'h00);
  endtask : t_clock_out
  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    idle(8);
    rstn <= 1'b1;
    idle(3);
    t_reset();
    t_port_a();
    t_port_b();
    t_clock_out();
    give_verdict();
  end
endmodule : test_three_port_gpio
`default_nettype wire
